// [rtl/tks_touch_key_scan_control.sv]
// Touch key scan control: burst sequencing, calibration, drift, debounce, output
// ----------------------------------------------------------------------
// Functional notes
// - Burst one measures keys 0,1,4,5; burst two measures keys 2,3,6,7.
// - The first burst group always runs before the second.
// - Low-power mode sleeps between acquisition bursts.
// - After power-up all eight key references calibrate within 300 ms.
// - Key recalibrates after continuous detect of 10 s or 60 s, or never.
// - Large capacitance decrease recalibrates that key after about two seconds.
// - Reference drifts one count per 2 s upward, per 500 ms downward.
// - Per-key counter advances above threshold, clears below, declares at limit.
// - Normal mode needs six consecutive bursts for touch start and release.
// - Fast-detect declares touch after two bursts; release still needs six.
// - Fast-detect only allowed when adjacent key suppression is disabled.
// - In sync mode each sync pulse runs one first then one second burst.
// - Touch confirmed in low-power mode wakes to full speed and asserts detect.
// - Stay at full speed until the host requests low-power again.
// - Suppression keeps only the dominant key of a group detecting.
// - Suppression groups: key pairs 0-1, 2-3, 4-5, 6-7, or the four keys of each burst.
// - Without suppression any number of keys may detect together.
// - One-per-key outputs, selectable push-pull/open-drain and polarity.
// - Binary mode shows index of the earliest touched key on three lines.
// - Simplified mode uses fixed settings; only grouping and low-power remain.
// - Detect output is active while any key is detected.
// - Sync or sleep request input acts on its rising edge.
// - Binary mode uses outputs 0 to 2; upper outputs are held low.
// ----------------------------------------------------------------------
`default_nettype none
module tks_touch_key_scan_control
    import tks_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,      // Clocks per time tick
    parameter int unsigned IDLE_TICKS  = 16,            // Ticks between full-speed scans
    parameter int unsigned SLEEP_TICKS = 256            // Ticks slept in low-power mode
) (
    input  wire logic       clk_in,                      // 25 MHz clock
    input  wire logic       nrst_in,                     // Async reset, active low
    input  wire logic       clk_en_in,                   // Freezes all state when low
    input  wire tks_cfg_t   cfg_in,                      // Strap configuration
    input  wire logic       low_power_mode_in,           // Low-power operation chosen
    input  wire logic       sync_or_sleep_request_in,    // Sync trigger or sleep request
    input  wire logic       burst_done_in,               // Analog burst finished
    input  wire logic [7:0] sample_delta_in [NKEYS],     // Per-key signal minus reference
    input  wire tks_meas_t  meas_in,                     // Per-key threshold verdicts
    output logic            burst_start_out,             // Pulse: start analog burst
    output logic [7:0]      burst_keys_out,              // Keys measured in burst
    output logic            sleeping_out,                // Minimal-current sleep
    output logic            calibrating_out,             // Power-up calibration busy
    output logic [7:0]      recal_key_out,               // Pulse: recalibrate key reference
    output logic [7:0]      drift_up_out,                // Pulse: reference up one count
    output logic [7:0]      drift_dn_out,                // Pulse: reference down one count
    output logic [7:0]      key_out,                     // Key output pin values
    output logic [7:0]      key_oe_out,                  // Key output pin enables
    output logic            detect_out,                  // Detect pin value
    output logic            detect_oe_out                // Detect pin enable
);
    // ------------------------------------------------------------------
    // Effective configuration
    // ------------------------------------------------------------------
    tks_cfg_t cfg;
    always_comb begin
        cfg = cfg_in;
        if (cfg_in.simplified) begin
            cfg.sync_mode   = 1'b0;
            cfg.fast_detect = 1'b0;
            cfg.binary_out  = 1'b0;
            cfg.open_drain  = 1'b0;
            cfg.active_low  = 1'b0;
            cfg.recal_sel   = RECAL_10S;
        end
        if (cfg.suppress_en)
            cfg.fast_detect = 1'b0;
    end

    // ------------------------------------------------------------------
    // Time tick and request edge
    // ------------------------------------------------------------------
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt, next_tick_cnt;
    logic                           tick;
    logic                           req_d, next_req_d;
    logic                           req_rise;
    assign tick     = (tick_cnt == '0);
    assign req_rise = sync_or_sleep_request_in & ~req_d;
    always_comb begin
        next_req_d    = sync_or_sleep_request_in;
        next_tick_cnt = tick ? ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1) : tick_cnt - 1'b1;
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_cnt <= '0;
            req_d    <= 1'b0;
        end else if (clk_en_in) begin
            tick_cnt <= next_tick_cnt;
            req_d    <= next_req_d;
        end
    end

    // ------------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------------
    tks_seq_t    state, next_state;
    logic [15:0] wait_cnt, next_wait_cnt;
    logic        lp_active, next_lp_active;
    logic        sync_pend, next_sync_pend;
    logic        any_detect;
    logic        new_touch;
    logic        burst_a_done, burst_b_done;
    assign burst_a_done = (state == SEQ_BURSTA) && burst_done_in;
    assign burst_b_done = (state == SEQ_BURSTB) && burst_done_in;

    always_comb begin
        next_state      = state;
        next_wait_cnt   = wait_cnt;
        next_lp_active  = lp_active;
        next_sync_pend  = sync_pend;
        burst_start_out = 1'b0;
        if (cfg.sync_mode && req_rise)
            next_sync_pend = 1'b1;
        if (!cfg.sync_mode && req_rise && low_power_mode_in)
            next_lp_active = 1'b1;
        if (new_touch && lp_active)
            next_lp_active = 1'b0;
        case (state)
            SEQ_CAL: begin
                if (tick)
                    next_wait_cnt = wait_cnt + 1'b1;
                if (wait_cnt >= 16'(CAL_TICKS)) begin
                    next_state    = SEQ_IDLE;
                    next_wait_cnt = '0;
                end
            end
            SEQ_IDLE: begin
                if (tick && !cfg.sync_mode)
                    next_wait_cnt = wait_cnt + 1'b1;
                if (cfg.sync_mode ? sync_pend : (wait_cnt >= 16'(IDLE_TICKS))) begin
                    next_sync_pend  = 1'b0;
                    burst_start_out = 1'b1;
                    next_state      = SEQ_BURSTA;
                end
            end
            SEQ_BURSTA: begin
                if (burst_done_in) begin
                    burst_start_out = 1'b1;
                    next_state      = SEQ_BURSTB;
                end
            end
            SEQ_BURSTB: begin
                if (burst_done_in) begin
                    next_wait_cnt = '0;
                    next_state    = (lp_active && !cfg.sync_mode) ? SEQ_SLEEP : SEQ_IDLE;
                end
            end
            SEQ_SLEEP: begin
                if (tick)
                    next_wait_cnt = wait_cnt + 1'b1;
                if (wait_cnt >= 16'(SLEEP_TICKS) || !lp_active) begin
                    burst_start_out = 1'b1;
                    next_state      = SEQ_BURSTA;
                end
            end
            default: next_state = SEQ_CAL;
        endcase
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state     <= SEQ_CAL;
            wait_cnt  <= '0;
            lp_active <= 1'b0;
            sync_pend <= 1'b0;
        end else if (clk_en_in) begin
            state     <= next_state;
            wait_cnt  <= next_wait_cnt;
            lp_active <= next_lp_active;
            sync_pend <= next_sync_pend;
        end
    end
    assign burst_keys_out  = (next_state == SEQ_BURSTB) ? GROUP_B_MASK : GROUP_A_MASK;
    assign sleeping_out    = (state == SEQ_SLEEP);
    assign calibrating_out = (state == SEQ_CAL);

    // ------------------------------------------------------------------
    // Suppression among keys of a group
    // ------------------------------------------------------------------
    function automatic logic [7:0] dominant(input logic [7:0] cand, input logic [7:0] grp,
                                            input logic [7:0] d [NKEYS]);
        logic [7:0] best;
        logic [7:0] win;
        best = '0;
        win  = '0;
        for (int i = 0; i < NKEYS; i++) begin
            if (grp[i] && cand[i] && d[i] > best) begin
                best = d[i];
                win  = 8'(1 << i);
            end
        end
        return win;
    endfunction

    logic [7:0] grp_mask, raw_hit, eff_hit, held;
    always_comb begin
        grp_mask = burst_a_done ? GROUP_A_MASK : GROUP_B_MASK;
        raw_hit  = meas_in.over_thresh & grp_mask;
        if (!cfg.suppress_en) begin
            eff_hit = raw_hit;
        end else if (cfg.suppress_all8) begin
            eff_hit = dominant(raw_hit | (held & grp_mask), grp_mask, sample_delta_in) & raw_hit;
        end else begin
            eff_hit = (dominant(raw_hit, grp_mask & HALF_LO_MASK, sample_delta_in) |
                       dominant(raw_hit, grp_mask & HALF_HI_MASK, sample_delta_in));
        end
    end

    // ------------------------------------------------------------------
    // Per-key confirmation, recalibration and drift timers
    // ------------------------------------------------------------------
    logic [7:0] touched;
    logic [7:0] new_touch_vec;
    logic [2:0] first_idx, next_first_idx;
    logic       first_valid, next_first_valid;
    logic [7:0] recal_vec, up_vec, dn_vec;
    logic [$clog2(RECAL_LONG_T+1)-1:0] recal_limit;
    always_comb begin
        case (cfg.recal_sel)
            RECAL_10S: recal_limit = ($clog2(RECAL_LONG_T+1))'(RECAL_SHORT_T);
            RECAL_60S: recal_limit = ($clog2(RECAL_LONG_T+1))'(RECAL_LONG_T);
            default:   recal_limit = '0;
        endcase
    end
    assign held = touched;

    genvar k;
    generate
        for (k = 0; k < NKEYS; k++) begin : g_key
            logic [2:0]  conf, next_conf;
            logic        tch, next_tch;
            logic [$clog2(RECAL_LONG_T+1)-1:0] on_t, next_on_t;
            logic [11:0] neg_t, next_neg_t, dr_t, next_dr_t;
            logic        done, recal, up, dn;
            assign done = (burst_a_done && GROUP_A_MASK[k]) || (burst_b_done && GROUP_B_MASK[k]);
            always_comb begin
                next_conf  = conf;
                next_tch   = tch;
                next_on_t  = on_t;
                next_neg_t = neg_t;
                next_dr_t  = dr_t;
                recal = 1'b0;
                up    = 1'b0;
                dn    = 1'b0;
                if (done) begin
                    if (eff_hit[k] != tch) begin
                        next_conf = conf + 1'b1;
                        if (next_conf >= ((!tch && cfg.fast_detect) ? CONFIRM_FAST
                                                                    : CONFIRM_NORM)) begin
                            next_tch  = ~tch;
                            next_conf = '0;
                        end
                    end else begin
                        next_conf = '0;
                    end
                end
                if (tick) begin
                    next_on_t = tch ? on_t + 1'b1 : '0;
                    next_neg_t = meas_in.neg_large[k] ? neg_t + 1'b1 : '0;
                    next_dr_t  = (tch || !(meas_in.under_ref[k] || meas_in.over_ref[k]))
                                 ? '0 : dr_t + 1'b1;
                end
                if (tch && recal_limit != '0 && on_t >= recal_limit) begin
                    recal     = 1'b1;
                    next_tch  = 1'b0;
                    next_conf = '0;
                    next_on_t = '0;
                end
                if (neg_t >= 12'(NEG_RECAL_T)) begin
                    recal      = 1'b1;
                    next_neg_t = '0;
                end
                if (meas_in.under_ref[k] && dr_t >= 12'(DRIFT_UP_T)) begin
                    up        = 1'b1;
                    next_dr_t = '0;
                end else if (meas_in.over_ref[k] && dr_t >= 12'(DRIFT_DN_T)) begin
                    dn        = 1'b1;
                    next_dr_t = '0;
                end
            end
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    conf  <= '0;
                    tch   <= 1'b0;
                    on_t  <= '0;
                    neg_t <= '0;
                    dr_t  <= '0;
                end else if (clk_en_in && state != SEQ_CAL) begin
                    conf  <= next_conf;
                    tch   <= next_tch;
                    on_t  <= next_on_t;
                    neg_t <= next_neg_t;
                    dr_t  <= next_dr_t;
                end
            end
            assign touched[k]       = tch;
            assign new_touch_vec[k] = next_tch & ~tch;
            assign recal_vec[k]     = recal | (state == SEQ_CAL && next_state != SEQ_CAL);
            assign up_vec[k]        = up;
            assign dn_vec[k]        = dn;
        end
    endgenerate
    assign new_touch  = |new_touch_vec;
    assign any_detect = |touched;

    // ------------------------------------------------------------------
    // Earliest touched key tracking
    // ------------------------------------------------------------------
    always_comb begin
        next_first_idx   = first_idx;
        next_first_valid = first_valid;
        if (first_valid && !touched[first_idx])
            next_first_valid = 1'b0;
        if (!next_first_valid && new_touch) begin
            for (int i = NKEYS - 1; i >= 0; i--) begin
                if (new_touch_vec[i]) begin
                    next_first_idx = 3'(i);
                end
            end
            next_first_valid = 1'b1;
        end else if (!next_first_valid && any_detect) begin
            for (int i = NKEYS - 1; i >= 0; i--) begin
                if (touched[i])
                    next_first_idx = 3'(i);
            end
            next_first_valid = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    logic [7:0] act, next_act;
    logic       det, next_det;
    always_comb begin
        next_det = |touched;
        if (cfg.binary_out)
            next_act = {5'h0_0, (first_valid ? first_idx : 3'h0)};
        else
            next_act = touched;
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_idx     <= '0;
            first_valid   <= 1'b0;
            act           <= '0;
            det           <= 1'b0;
            recal_key_out <= '0;
            drift_up_out  <= '0;
            drift_dn_out  <= '0;
        end else if (clk_en_in) begin
            first_idx     <= next_first_idx;
            first_valid   <= next_first_valid;
            act           <= next_act;
            det           <= next_det;
            recal_key_out <= recal_vec;
            drift_up_out  <= up_vec;
            drift_dn_out  <= dn_vec;
        end
    end
    always_comb begin
        if (cfg.binary_out) begin
            key_out    = act;
            key_oe_out = 8'hFF;
        end else if (cfg.open_drain) begin
            key_out    = 8'h00;
            key_oe_out = cfg.active_low ? act : ~act;
        end else begin
            key_out    = cfg.active_low ? ~act : act;
            key_oe_out = 8'hFF;
        end
        if (cfg.open_drain && !cfg.binary_out) begin
            detect_out    = 1'b0;
            detect_oe_out = cfg.active_low ? det : ~det;
        end else begin
            detect_out    = cfg.active_low ? ~det : det;
            detect_oe_out = 1'b1;
        end
    end
endmodule // tks_touch_key_scan_control
`default_nettype wire

// [shared/tks_pkg.sv]
// Package of constants and types for the touch key scan control block
`default_nettype none
package tks_pkg;
    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned CAL_TIME_MS   = 300;
    localparam int unsigned RECAL_SHORT_S = 10;
    localparam int unsigned RECAL_LONG_S  = 60;
    localparam int unsigned NEG_RECAL_MS  = 2000;
    localparam int unsigned DRIFT_UP_MS   = 2000;
    localparam int unsigned DRIFT_DN_MS   = 500;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned TICK_CYC      = (CLK_HZ / 1000) * TICK_MS;
    localparam int unsigned CAL_TICKS     = CAL_TIME_MS / TICK_MS;
    localparam int unsigned RECAL_SHORT_T = RECAL_SHORT_S * 1000 / TICK_MS;
    localparam int unsigned RECAL_LONG_T  = RECAL_LONG_S * 1000 / TICK_MS;
    localparam int unsigned NEG_RECAL_T   = NEG_RECAL_MS / TICK_MS;
    localparam int unsigned DRIFT_UP_T    = DRIFT_UP_MS / TICK_MS;
    localparam int unsigned DRIFT_DN_T    = DRIFT_DN_MS / TICK_MS;
    // ------------------------------------------------------------------
    // Key layout and debounce counts
    // ------------------------------------------------------------------
    localparam int unsigned NKEYS         = 8;
    localparam logic [7:0]  GROUP_A_MASK  = 8'h33;
    localparam logic [7:0]  GROUP_B_MASK  = 8'hCC;
    localparam logic [7:0]  HALF_LO_MASK  = 8'h0F;
    localparam logic [7:0]  HALF_HI_MASK  = 8'hF0;
    localparam logic [2:0]  CONFIRM_NORM  = 3'h6;
    localparam logic [2:0]  CONFIRM_FAST  = 3'h2;
    localparam logic [15:0] SIGNAL_RESET  = 16'h0000;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_CAL    = 3'b000,
        SEQ_IDLE   = 3'b001,
        SEQ_BURSTA = 3'b010,
        SEQ_BURSTB = 3'b011,
        SEQ_SLEEP  = 3'b100
    } tks_seq_t;
    typedef enum logic [1:0] {
        RECAL_10S  = 2'b00,
        RECAL_60S  = 2'b01,
        RECAL_OFF  = 2'b10
    } tks_recal_t;
    typedef struct packed {
        logic       simplified;
        logic       sync_mode;
        logic       fast_detect;
        logic       suppress_en;
        logic       suppress_all8;
        logic       binary_out;
        logic       open_drain;
        logic       active_low;
        tks_recal_t recal_sel;
    } tks_cfg_t;
    // Measurement results for one burst: per-key threshold verdicts
    typedef struct packed {
        logic [7:0] over_thresh;
        logic [7:0] under_ref;
        logic [7:0] over_ref;
        logic [7:0] neg_large;
    } tks_meas_t;
endpackage : tks_pkg
`default_nettype wire

// [verification/tks_scan_checker.sv]
// Assertion checker for the touch key scan control block
`default_nettype none
module tks_scan_checker
    import tks_pkg::*;
(
    input wire logic       clk_in,            // Clock
    input wire logic       nrst_in,           // Reset, active low
    input wire tks_cfg_t   cfg_in,            // Straps
    input wire logic       low_power_mode_in, // Low-power chosen
    input wire logic       burst_start_out,   // Burst start
    input wire logic [7:0] burst_keys_out,    // Burst keys
    input wire logic       sleeping_out,      // Sleeping
    input wire logic       calibrating_out,   // Calibrating
    input wire logic [7:0] recal_key_out,     // Recal pulses
    input wire logic [7:0] drift_up_out,      // Drift up
    input wire logic [7:0] drift_dn_out,      // Drift down
    input wire logic [7:0] key_out,           // Key pins
    input wire logic       detect_out         // Detect pin
);
    logic last_a;
    logic next_last_a;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Remembers whether the last burst started was the first group
    always_comb begin
        next_last_a = last_a;
        if (burst_start_out) next_last_a = (burst_keys_out == 8'h33);
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) last_a <= 1'h0;
        else last_a <= next_last_a;
    end
    a_burst_keys: assert property (burst_start_out |-> burst_keys_out inside {8'h33, 8'hcc})
        else $error("burst started with wrong key set");
    a_group_order: assert property (burst_start_out |-> (burst_keys_out == 8'hcc) == last_a)
        else $error("burst groups out of order");
    a_cal_quiet: assert property (calibrating_out |-> !burst_start_out)
        else $error("burst during calibration");
    a_cal_recal: assert property ($fell(calibrating_out) |-> ##[0:1] recal_key_out == 8'hff)
        else $error("no recalibration of all keys after calibration");
    a_sleep_quiet: assert property (sleeping_out |-> (low_power_mode_in and (burst_start_out |=> !sleeping_out)))
        else $error("burst or sleep outside low power");
    a_drift_one: assert property ((drift_up_out & drift_dn_out) == 8'h00)
        else $error("drift both ways at once");
    a_detect_any: assert property (!cfg_in.binary_out && !cfg_in.active_low && !cfg_in.open_drain
        |-> detect_out == (|key_out))
        else $error("detect does not follow keys");
    a_bin_upper: assert property (cfg_in.binary_out && !cfg_in.simplified |-> key_out[7:3] == 5'h00)
        else $error("upper outputs active in binary mode");
endmodule // tks_scan_checker
bind tks_touch_key_scan_control tks_scan_checker u_chk (.clk_in, .nrst_in, .cfg_in,
    .low_power_mode_in, .burst_start_out, .burst_keys_out, .sleeping_out, .calibrating_out,
    .recal_key_out, .drift_up_out, .drift_dn_out, .key_out, .detect_out);
`default_nettype wire

// [verification/tks_sense_model.sv]
// Analog burst engine model answering burst starts after a random delay
`default_nettype none
module tks_sense_model (
    input  wire logic       clk_in,    // Clock
    input  wire logic       start_in,  // Burst start pulse
    input  wire logic [7:0] keys_in,   // Keys of burst
    output logic            done_out,  // Burst finished pulse
    output int              a_cnt_out  // First-group bursts finished
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       req = 1'h0;
    logic [7:0] keys;
    initial done_out = 1'h0;
    initial a_cnt_out = 0;
    always @(posedge clk_in) if (start_in) begin
        req = 1'h1;
        keys = keys_in;
    end
    always begin
        @(negedge clk_in);
        done_out = 1'h0;
        if (req) begin
            req = 1'h0;
            repeat ($urandom_range(20, 1)) @(negedge clk_in);
            done_out = 1'h1;
            if (keys == 8'h33) a_cnt_out++;
        end
    end
endmodule // tks_sense_model
`default_nettype wire

// [verification/tks_touch_key_scan_control_test.sv]
// Self-checking testbench for the touch key scan control block
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tks_touch_key_scan_control_test
    import tks_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'h0, nrst_in = 1'h0, clk_en_in = 1'h1, low_power_mode_in = 1'h0;
    logic sync_or_sleep_request_in = 1'h0, burst_done_in, burst_start_out, sleeping_out;
    logic calibrating_out;
    logic [7:0] burst_keys_out, key_out, key_oe_out, sample_delta_in [NKEYS];
    tks_cfg_t  cfg_in = '0;
    tks_meas_t meas_in = '0;
    int fail_count = 0, check_count = 0, a_cnt;
    tks_touch_key_scan_control #(.TICK_CYCLES(4), .IDLE_TICKS(2), .SLEEP_TICKS(4)) DUT (
        .clk_in, .nrst_in, .clk_en_in, .cfg_in, .low_power_mode_in, .sync_or_sleep_request_in,
        .burst_done_in, .sample_delta_in, .meas_in, .burst_start_out, .burst_keys_out,
        .sleeping_out, .calibrating_out, .recal_key_out(), .drift_up_out(), .drift_dn_out(),
        .key_out, .key_oe_out, .detect_out(), .detect_oe_out());
    tks_sense_model u_sense (.clk_in, .start_in(burst_start_out), .keys_in(burst_keys_out),
        .done_out(burst_done_in), .a_cnt_out(a_cnt));
    initial forever #20 clk_in = ~clk_in;
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Waits for the next first-group burst to finish and be taken
    task automatic sync_a();
        int c;
        c = a_cnt;
        wait (a_cnt != c);
        @(negedge clk_in);
    endtask
    task automatic step(input logic [7:0] m, input int n, input logic [7:0] e);
        meas_in.over_thresh = m;
        repeat (n) sync_a();
        repeat (2) @(negedge clk_in);
        `CHK(key_out, e)
    endtask
    task automatic watch(input logic e);
        logic s;
        s = 1'h0;
        repeat (80) begin
            @(negedge clk_in);
            s |= sleeping_out;
        end
        `CHK(s, e)
    endtask
    initial begin
        logic [7:0] m;
        void'($urandom(32'h0000_a8e6));
        foreach (sample_delta_in[i]) sample_delta_in[i] = 8'h40;
        repeat (3) @(negedge clk_in);
        nrst_in = 1'h1;
        @(negedge clk_in);
        `CHK(calibrating_out, 1'h1)
        repeat (1300) @(negedge clk_in);
        `CHK(calibrating_out, 1'h0)
        $display("test calibration done");
        step(8'h01, 5, 8'h00);
        step(8'h01, 1, 8'h01);
        step(8'h00, 5, 8'h01);
        step(8'h00, 1, 8'h00);
        cfg_in.fast_detect = 1'h1;
        step(8'h10, 1, 8'h00);
        step(8'h10, 1, 8'h10);
        step(8'h00, 5, 8'h10);
        step(8'h00, 1, 8'h00);
        cfg_in.suppress_en = 1'h1;
        sample_delta_in[1] = 8'h50;
        step(8'h03, 2, 8'h00);
        step(8'h03, 4, 8'h02);
        step(8'h00, 6, 8'h00);
        cfg_in = '0;
        $display("test debounce done");
        repeat (4) begin
            m = 8'($urandom) & 8'h33;
            step(m, 6, m);
            step(8'h00, 6, 8'h00);
        end
        cfg_in.binary_out = 1'h1;
        step(8'h20, 6, 8'h05);
        step(8'h22, 6, 8'h05);
        step(8'h00, 6, 8'h00);
        cfg_in = '0;
        cfg_in.active_low = 1'h1;
        cfg_in.open_drain = 1'h1;
        repeat (2) @(negedge clk_in);
        `CHK(key_oe_out, 8'h00)
        cfg_in = '0;
        $display("test outputs done");
        low_power_mode_in = 1'h1;
        sync_or_sleep_request_in = 1'h1;
        watch(1'h1);
        step(8'h01, 6, 8'h01);
        watch(1'h0);
        $display("test low power done");
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        give_verdict();
    end
endmodule // tks_touch_key_scan_control_test
`default_nettype wire
